//--- rtl/voice_cmd_regs.svh
`ifndef VOICE_CMD_REGS_SVH
`define VOICE_CMD_REGS_SVH

// opcodes in command bits 15..10
`define OP_LOAD        6'h25
`define OP_PLAY        6'h26
`define OP_PU_DIRECT   6'h29
`define OP_PU_RAMPED   6'h2a
`define OP_PD_DIRECT   6'h2d
`define OP_PD_RAMPED   6'h2e
`define OP_VOL_SET     6'h11
`define OP_VOL_UP      6'h12
`define OP_VOL_DOWN    6'h15
`define OP_PAUSE       6'h19
`define OP_RESUME      6'h1a
`define OP_STATUS      6'h3f

// status word bit positions
`define ST_TAG_HI      8
`define ST_PLAYING_LOW 7
`define ST_PENDING_LOW 6
`define ST_VALID_LOW   2
`define ST_PARITY      1
`define ST_TAG_LO      0

// timing
`define CLK_HZ         25000000
`define RAMP_MS        160
`define RAMP_CYCLES    ((`CLK_HZ / 1000) * `RAMP_MS)
`define DAC_BOTTOM     16'h0000
`define DAC_CENTRE     16'h8000

`endif

//--- rtl/voice_cmd_pkg.sv
package voice_cmd_pkg;
    typedef enum logic [2:0] {
        PWR_OFF     = 3'b000,
        PWR_RAMP_UP = 3'b001,
        PWR_ON      = 3'b010,
        PWR_RAMP_DN = 3'b011
    } power_e;
    typedef logic [15:0] word_t;
    typedef logic [9:0]  group_t;
endpackage

//--- rtl/two_wire_voice_command_port.sv
`timescale 1ns/1ns
`include "voice_cmd_regs.svh"
// Contract
// (R01) host changes data while clock low; device samples at clock rising edge
// (R02) host waits over 300 us after start on power-up command
// (R03) host waits for configuration end, then sends stop, before commands
// (R04) direct power-up sets output straight to centre and holds
// (R05) ramped power-up ramps output bottom to centre over 160 ms
// (R06) direct power-down drops output to bottom at once
// (R07) ramped power-down ramps output present level to bottom over 160 ms
// (R08) load takes 10-bit group; load indication goes high
// (R09) load indication falls once loaded group played, buffer free
// (R10) play takes 10-bit group and starts playback immediately
// (R11) volume set from low 4, 3 or 2 bits; 0 loudest
// (R12) volume up raises one level, volume down lowers one level
// (R13) pause holds pwm outputs low and dac level; resume continues; a dac ramp runs on while paused
// (R14) fourth key pin serves as status data output
// (R15) status command top six bits all ones; device shifts status out
// (R16) status output bit changes on falling serial clock edge
// (R17) bits 8 and 0 toggle on each valid command; others reserved
// (R18) bit 7 reads 0 while playing, else 1
// (R19) bit 6 reads 0 while loaded group waits, else 1
// (R20) bit 2 reads 0 if last command valid, else 1
// (R21) bit 1 reads 0 when group address ones count odd
// (R22) 16-bit commands, msb first, decoded by bits 15 to 10
// (R23) indicator output shows busy during playback and ramping
// (R24) unknown opcodes ignored and reported invalid
// (R25) volume up and down saturate at ends
module two_wire_voice_command_port #(
    parameter int          VOL_BITS    = 4,
    parameter int unsigned RAMP_CYCLES = `RAMP_CYCLES
) (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire logic                  serialClockPin,
    input  wire logic                  serialDataInPin,
    input  wire logic                  stopCondition,
    output logic                       statusOutPin,
    output logic                       statusOutEn,
    output logic                       programmableIndicatorOutput,
    output logic                       loadIndication,
    input  wire logic                  voiceDone,
    output logic                       playStart,
    output voice_cmd_pkg::group_t      playGroup,
    output logic                       playing,
    output logic [VOL_BITS-1:0]        volumeLevel,
    output logic                       paused,
    output logic                       powered,
    output logic                       pwmSpeakerOutA,
    output logic                       pwmSpeakerOutB,
    input  wire logic                  pwmSourceA,
    input  wire logic                  pwmSourceB,
    output logic [15:0]                dacCurrentOutput
);
    import voice_cmd_pkg::*;

    initial begin
        if (VOL_BITS < 2 || VOL_BITS > 4) $error("VOL_BITS must be 2..4");
        if (RAMP_CYCLES < 2) $error("RAMP_CYCLES too small");
    end

    // ------------------------------------------------------------
    // link domain: shifter on serial clock
    // ------------------------------------------------------------
    // bits enter on rising serial edges
    // the sixteenth bit completes a word
    // stop level clears the bit count
    // readout runs on falling edges, so
    // each bit settles before next rise
    // no timeout: a partial word waits
    logic [15:0] shift_r;
    logic [3:0]  bitCnt_r;
    logic        wordTgl_r;
    word_t       word_r;
    logic        sendAct_r;
    logic [4:0]  outCnt_r;
    logic        outBit_r;
    logic        outEn_r;
    word_t       statSnap;
    word_t       statHold_r;
    logic        seenTglLink_r;
    logic [15:0] shiftNxt;
    assign shiftNxt = {shift_r[14:0], serialDataInPin};

    // collect bits at rising edge; stop resynchronises framing
    always_ff @(posedge serialClockPin or negedge nrst) begin
        if (!nrst) begin
            shift_r   <= 16'h0000;
            bitCnt_r  <= 4'h0;
            wordTgl_r <= 1'b0;
            word_r    <= 16'h0000;
        end else if (stopCondition) begin
            bitCnt_r <= 4'h0;
        end else begin
            shift_r  <= shiftNxt;                               // R01
            bitCnt_r <= bitCnt_r + 4'h1;                        // R22
            if (bitCnt_r == 4'hf) begin
                word_r    <= shiftNxt;
                wordTgl_r <= ~wordTgl_r;
            end
        end
    end

    // status shifted out on falling edge after a status command
    // word frozen at the first edge: all bits from one moment
    // count runs 14 to 0, then wraps; the wrap ends the readout
    // so bit 0 stands a full serial period with enable high
    always_ff @(negedge serialClockPin or negedge nrst) begin
        if (!nrst) begin
            sendAct_r  <= 1'b0;
            outCnt_r   <= 5'h00;
            outBit_r   <= 1'b0;
            outEn_r    <= 1'b0;
            statHold_r <= 16'h0000;
        end else if (!sendAct_r && bitCnt_r == 4'h0 && word_r[15:10] == `OP_STATUS
                     && wordTgl_r != seenTglLink_r) begin
            sendAct_r  <= 1'b1;                                 // R15
            outCnt_r   <= 5'h0e;
            outBit_r   <= statSnap[15];                         // R16
            outEn_r    <= 1'b1;                                 // R14
            statHold_r <= statSnap;
        end else if (sendAct_r) begin
            outCnt_r <= outCnt_r - 5'h01;
            if (outCnt_r[4]) begin
                sendAct_r <= 1'b0;
                outEn_r   <= 1'b0;
            end else begin
                outBit_r <= statHold_r[outCnt_r[3:0]];          // R16
            end
        end
    end

    // remember which word was already answered
    always_ff @(negedge serialClockPin or negedge nrst) begin
        if (!nrst) seenTglLink_r <= 1'b0;
        else if (bitCnt_r == 4'h0) seenTglLink_r <= wordTgl_r;
    end

    assign statusOutPin = outBit_r;
    assign statusOutEn  = outEn_r;

    // ------------------------------------------------------------
    // crossing: word toggle into core, status word into link
    // ------------------------------------------------------------
    // toggle passes three flops; last two
    // form the edge detector: one pulse
    // per completed word in the core
    // status bits pass two serial-clock flops each
    logic [2:0] tglSync_r;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) tglSync_r <= 3'b000;
        else tglSync_r <= {tglSync_r[1:0], wordTgl_r};
    end
    wire wordEvt = tglSync_r[2] ^ tglSync_r[1];

    // status word held stable in core; the link reads it only after a full
    // word has arrived, many core cycles after any change it depends on
    word_t status_r;
    logic [1:0] statSync0_r [16];
    always_ff @(posedge serialClockPin or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 16; i++) statSync0_r[i] <= 2'b00;
        end else begin
            for (int i = 0; i < 16; i++)
                statSync0_r[i] <= {statSync0_r[i][0], status_r[i]};
        end
    end
    always_comb begin
        statSnap = 16'h0000;
        for (int i = 0; i < 16; i++) statSnap[i] = statSync0_r[i][1];
    end

    // ------------------------------------------------------------
    // core: decode
    // ------------------------------------------------------------
    // opcode read from the link word; it
    // only changes on the next word's end,
    // long after the toggle event arrives
    // status request counts as valid: it
    // flips the tag, clears invalid flag
    // validity judged on all six bits
    wire [5:0] opc  = word_r[15:10];
    wire isLoad     = opc == `OP_LOAD;
    wire isPlay     = opc == `OP_PLAY;
    wire isPuD      = opc == `OP_PU_DIRECT;
    wire isPuR      = opc == `OP_PU_RAMPED;
    wire isPdD      = opc == `OP_PD_DIRECT;
    wire isPdR      = opc == `OP_PD_RAMPED;
    wire isVSet     = opc == `OP_VOL_SET;
    wire isVUp      = opc == `OP_VOL_UP;
    wire isVDn      = opc == `OP_VOL_DOWN;
    wire isPause    = opc == `OP_PAUSE;
    wire isResume   = opc == `OP_RESUME;
    wire isStat     = opc == `OP_STATUS;
    wire validCmd   = isLoad | isPlay | isPuD | isPuR | isPdD | isPdR | isVSet
                    | isVUp | isVDn | isPause | isResume | isStat;      // R24
    wire cmdGo      = wordEvt & validCmd;

    // ------------------------------------------------------------
    // core: playback, load queue, volume, status flags
    // ------------------------------------------------------------
    // play starts at once; a queued group still waits
    // a load starts once player is idle
    // or when the current group ends
    // load beats a same-cycle end: the end is lost
    // pause freezes end handling
    // higher code is quieter: up subtracts
    logic   playing_r, pending_r, paused_r, tag_r, invalid_r, parity_r, start_r;
    group_t group_r, queued_r;
    logic [VOL_BITS-1:0] vol_r;
    localparam logic [VOL_BITS-1:0] VOL_MIN = '1;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            playing_r <= 1'b0;
            pending_r <= 1'b0;
            paused_r  <= 1'b0;
            tag_r     <= 1'b0;
            invalid_r <= 1'b0;
            parity_r  <= 1'b1;
            start_r   <= 1'b0;
            group_r   <= 10'h000;
            queued_r  <= 10'h000;
            vol_r     <= '0;
        end else begin
            start_r <= 1'b0;
            if (wordEvt) invalid_r <= ~validCmd;                // R20 R24
            if (cmdGo) tag_r <= ~tag_r;                         // R17
            if (cmdGo && (isLoad || isPlay))
                parity_r <= ~(^word_r[9:0]);                    // R21
            if (cmdGo && isPlay) begin
                group_r   <= word_r[9:0];                       // R10
                playing_r <= 1'b1;
                start_r   <= 1'b1;
                paused_r  <= 1'b0;
            end else if (cmdGo && isLoad) begin
                queued_r  <= word_r[9:0];                       // R08
                pending_r <= 1'b1;
            end else if (playing_r && voiceDone && !paused_r) begin
                if (pending_r) begin
                    group_r   <= queued_r;
                    start_r   <= 1'b1;
                    pending_r <= 1'b0;                          // R09
                end else begin
                    playing_r <= 1'b0;
                end
            end else if (!playing_r && pending_r) begin
                group_r   <= queued_r;
                playing_r <= 1'b1;
                start_r   <= 1'b1;
                pending_r <= 1'b0;                              // R09
            end
            if (cmdGo && isPause) paused_r <= 1'b1;             // R13
            if (cmdGo && isResume) paused_r <= 1'b0;            // R13
            if (cmdGo && isVSet) vol_r <= word_r[VOL_BITS-1:0]; // R11
            if (cmdGo && isVUp && vol_r != '0) vol_r <= vol_r - 1'b1;   // R12 R25
            if (cmdGo && isVDn && vol_r != VOL_MIN) vol_r <= vol_r + 1'b1; // R12 R25
        end
    end

    // ------------------------------------------------------------
    // core: power and dac ramp
    // ------------------------------------------------------------
    // counter runs only while ramping
    // dac scales linearly bottom to centre
    // ramp down starts from present level
    // power commands mid-ramp are ignored
    // product kept wide against overflow
    power_e pwr_r;
    logic [31:0] rampCnt_r;
    logic [15:0] dac_r, rampStart_r;
    wire rampEnd = rampCnt_r == RAMP_CYCLES - 1;
    logic [47:0] prod;
    assign prod = 48'(rampStart_r) * 48'(RAMP_CYCLES - 1 - rampCnt_r);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pwr_r       <= PWR_OFF;
            rampCnt_r   <= 32'h0;
            dac_r       <= `DAC_BOTTOM;
            rampStart_r <= `DAC_BOTTOM;
        end else begin
            case (pwr_r)
                PWR_OFF, PWR_ON: begin
                    rampCnt_r <= 32'h0;
                    if (cmdGo && isPuD) begin
                        pwr_r <= PWR_ON;
                        dac_r <= `DAC_CENTRE;                   // R04
                    end else if (cmdGo && isPuR) begin
                        pwr_r <= PWR_RAMP_UP;                   // R05
                        dac_r <= `DAC_BOTTOM;
                    end else if (cmdGo && isPdD) begin
                        pwr_r <= PWR_OFF;
                        dac_r <= `DAC_BOTTOM;                   // R06
                    end else if (cmdGo && isPdR) begin
                        pwr_r       <= PWR_RAMP_DN;             // R07
                        rampStart_r <= dac_r;
                    end
                end
                PWR_RAMP_UP: begin
                    rampCnt_r <= rampCnt_r + 32'h1;
                    dac_r <= 16'((48'(`DAC_CENTRE) * 48'(rampCnt_r + 1)) / 48'(RAMP_CYCLES)); // R05
                    if (rampEnd) begin
                        pwr_r <= PWR_ON;
                        dac_r <= `DAC_CENTRE;
                    end
                end
                PWR_RAMP_DN: begin
                    rampCnt_r <= rampCnt_r + 32'h1;
                    dac_r <= 16'(prod / 48'(RAMP_CYCLES));      // R07
                    if (rampEnd) begin
                        pwr_r <= PWR_OFF;
                        dac_r <= `DAC_BOTTOM;
                    end
                end
                default: pwr_r <= PWR_OFF;
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // busy and pwm registered: one clock behind
    // busy covers playback and both ramps
    // pwm low while paused or idle; dac
    // keeps its level only when no ramp runs
    // powered high in every state but off
    wire ramping = (pwr_r == PWR_RAMP_UP) || (pwr_r == PWR_RAMP_DN);
    logic ind_r, pwmA_r, pwmB_r;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ind_r  <= 1'b0;
            pwmA_r <= 1'b0;
            pwmB_r <= 1'b0;
        end else begin
            ind_r  <= playing_r | ramping;                      // R23
            pwmA_r <= pwmSourceA & ~paused_r & playing_r;       // R13
            pwmB_r <= pwmSourceB & ~paused_r & playing_r;       // R13
        end
    end

    // status word assembly; reserved bits zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) status_r <= 16'h0000;
        else begin
            status_r                  <= 16'h0000;
            status_r[`ST_TAG_HI]      <= tag_r;                 // R17
            status_r[`ST_TAG_LO]      <= tag_r;                 // R17
            status_r[`ST_PLAYING_LOW] <= ~playing_r;            // R18
            status_r[`ST_PENDING_LOW] <= ~pending_r;            // R19
            status_r[`ST_VALID_LOW]   <= invalid_r;             // R20
            status_r[`ST_PARITY]      <= parity_r;              // R21
        end
    end

    assign programmableIndicatorOutput = ind_r;
    assign loadIndication   = pending_r;                        // R08 R09
    assign playStart        = start_r;
    assign playGroup        = group_r;
    assign playing          = playing_r;
    assign volumeLevel      = vol_r;
    assign paused           = paused_r;
    assign powered          = pwr_r != PWR_OFF;
    assign pwmSpeakerOutA   = pwmA_r;
    assign pwmSpeakerOutB   = pwmB_r;
    assign dacCurrentOutput = dac_r;                            // R13
endmodule // two_wire_voice_command_port

//--- tb/voice_cmd_chk.sv
`timescale 1ns/1ns
module voice_cmd_chk #(
    parameter int unsigned RAMP_CYCLES = 16
) (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        playStart,
    input wire logic        playing,
    input wire logic        programmableIndicatorOutput,
    input wire logic        loadIndication,
    input wire logic        paused,
    input wire logic        pwmSpeakerOutA,
    input wire logic        pwmSpeakerOutB,
    input wire logic        pwmSourceA,
    input wire logic [15:0] dacCurrentOutput
);
    // ----------------------------------------
    // ramp tracking
    // ----------------------------------------
    int unsigned rampCnt_r;
    logic        midRamp;
    // dac strictly between bottom and centre while running
    assign midRamp = (dacCurrentOutput != 16'h0000) && (dacCurrentOutput != 16'h8000) && !paused;
    // length of the ramp in progress
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rampCnt_r <= 0;
        end else begin
            rampCnt_r <= midRamp ? rampCnt_r + 1 : 0;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    start_pulse_a: assert property (playStart |=> !playStart)
        else $error("play start longer than one cycle");
    start_plays_a: assert property (playStart |=> playing)
        else $error("play start without playback");
    busy_play_a: assert property (playing |=> programmableIndicatorOutput)
        else $error("busy low while playing");
    busy_ramp_a: assert property (midRamp |-> ##[0:1] programmableIndicatorOutput)
        else $error("busy low while ramping");
    ramp_len_a: assert property (rampCnt_r <= RAMP_CYCLES)
        else $error("ramp longer than its span");
    dac_ceiling_a: assert property (dacCurrentOutput <= 16'h8000)
        else $error("dac above centre");
    pause_pwm_a: assert property (paused && $past(paused) |-> !pwmSpeakerOutA && !pwmSpeakerOutB)
        else $error("pwm active while paused");
    pause_dac_a: assert property (paused && $past(paused) |-> $stable(dacCurrentOutput))
        else $error("dac moved while paused");
    pwm_copy_a: assert property ($past(playing) && !$past(paused) |-> pwmSpeakerOutA == $past(pwmSourceA))
        else $error("pwm does not follow source");
    load_fall_a: assert property ($fell(loadIndication) |-> ##[0:2] playing)
        else $error("load cleared without playback");
endmodule // voice_cmd_chk

//--- tb/host_model.sv
`timescale 1ns/1ns
`include "voice_cmd_regs.svh"
module host_model (
    output logic      serialClockPin,
    output logic      serialDataInPin,
    output logic      stopCondition,
    input  wire logic statusOutPin,
    input  wire logic statusOutEn
);
    // clock stands low between frames
    initial begin
        serialClockPin = 1'b0;
        serialDataInPin = 1'b0;
        stopCondition = 1'b0;
    end
    // one 15 ns clock pulse, data set only while low
    task automatic pulse(input logic bitVal);
        serialDataInPin = bitVal;
        #7;
        serialClockPin = 1'b1;
        #8;
        serialClockPin = 1'b0;
    endtask
    // msb first word, power-up waits for wake after frame start
    task automatic send_word(input voice_cmd_pkg::word_t w);
        for (int i = 15; i >= 0; i--) begin
            pulse(w[i]);
            if (i == 15 && (w[15:10] == `OP_PU_DIRECT || w[15:10] == `OP_PU_RAMPED)) begin
                #301000;
            end
        end
        serialDataInPin = ~w[0];
    endtask
    // stop after configuration before any command
    task automatic stop_frame;
        stopCondition = 1'b1;
        pulse(1'b0);
        stopCondition = 1'b0;
        serialDataInPin = 1'b1;
    endtask
    // status request, then 16 clocks; each bit taken after a rise
    task automatic read_status(output voice_cmd_pkg::word_t st, output logic en);
        send_word(16'hffff);
        #400;
        en = 1'b1;
        for (int i = 15; i >= 0; i--) begin
            serialDataInPin = 1'b1;
            #7;
            serialClockPin = 1'b1;
            #3;
            st[i] = statusOutPin;
            en = en & statusOutEn;
            #5;
            serialClockPin = 1'b0;
        end
        serialDataInPin = 1'b0;
    endtask
endmodule // host_model

//--- tb/testbench.sv
`timescale 1ns/1ns
`include "voice_cmd_regs.svh"
module testbench;
    import voice_cmd_pkg::*;
    localparam int unsigned RAMP = 16;
    logic            clk, nrst, voiceDone, pwmSourceA, pwmSourceB, en;
    wire logic       serialClockPin, serialDataInPin, stopCondition, statusOutPin, statusOutEn;
    wire logic       programmableIndicatorOutput, loadIndication, playStart, playing;
    wire logic       paused, powered, pwmSpeakerOutA, pwmSpeakerOutB;
    wire group_t     playGroup;
    wire logic [3:0] volumeLevel;
    wire logic [15:0] dacCurrentOutput;
    int              errors, checks;
    word_t           st;

    two_wire_voice_command_port #(.VOL_BITS(4), .RAMP_CYCLES(RAMP)) two_wire_voice_command_port_inst (
        .clk, .nrst, .serialClockPin, .serialDataInPin, .stopCondition, .statusOutPin,
        .statusOutEn, .programmableIndicatorOutput, .loadIndication, .voiceDone, .playStart,
        .playGroup, .playing, .volumeLevel, .paused, .powered, .pwmSpeakerOutA,
        .pwmSpeakerOutB, .pwmSourceA, .pwmSourceB, .dacCurrentOutput);
    host_model host_model_inst (.serialClockPin, .serialDataInPin, .stopCondition,
        .statusOutPin, .statusOutEn);

    // core clock and toggling pwm sources
    initial clk = 1'b0;
    always #20 clk = ~clk;
    always @(posedge clk) begin
        #1;
        pwmSourceA = ~pwmSourceA;
        pwmSourceB = ~pwmSourceB;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cmd(input word_t w);
        host_model_inst.send_word(w);
        wait_clk(8);
    endtask
    task automatic rd;
        host_model_inst.read_status(st, en);
        check(en, 1);
    endtask
    task automatic done_pulse;
        @(posedge clk);
        #1;
        voiceDone = 1'b1;
        @(posedge clk);
        #1;
        voiceDone = 1'b0;
    endtask
    task automatic wait_start;
        int n;
        n = 0;
        while (playStart !== 1'b1 && n < 20) begin
            wait_clk(1);
            n++;
        end
        check(n < 20, 1);
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_power;
        cmd({`OP_PU_DIRECT, 10'h000});
        check(dacCurrentOutput, `DAC_CENTRE);
        check(powered, 1);
        cmd({`OP_PD_DIRECT, 10'h000});
        check(dacCurrentOutput, `DAC_BOTTOM);
        check(powered, 0);
        cmd({`OP_PU_RAMPED, 10'h000});
        check(programmableIndicatorOutput, 1);
        check(dacCurrentOutput > 0 && dacCurrentOutput < `DAC_CENTRE, 1);
        wait_clk(RAMP + 4);
        check(dacCurrentOutput, `DAC_CENTRE);
        check(programmableIndicatorOutput, 0);
        cmd({`OP_PD_RAMPED, 10'h000});
        check(dacCurrentOutput > 0 && dacCurrentOutput < `DAC_CENTRE, 1);
        wait_clk(RAMP + 4);
        check(dacCurrentOutput, `DAC_BOTTOM);
        cmd({`OP_PU_DIRECT, 10'h000});
    endtask
    task automatic t_play;
        group_t g1, g2;
        g1 = 10'h2b5;
        g2 = 10'h001;
        host_model_inst.send_word({`OP_PLAY, g1});
        wait_start;
        check(playGroup, g1);
        wait_clk(2);
        check(programmableIndicatorOutput, 1);
        rd;
        check(st[7], 0);
        check(st[6], 1);
        check(st[1], ~^g1);
        check(st[8], st[0]);
        cmd({`OP_LOAD, g2});
        check(loadIndication, 1);
        rd;
        check(st[6], 0);
        check(st[1], ~^g2);
        done_pulse;
        wait_start;
        check(playGroup, g2);
        wait_clk(2);
        check(loadIndication, 0);
        done_pulse;
        wait_clk(4);
        check(playing, 0);
        rd;
        check(st[7], 1);
    endtask
    task automatic t_pause;
        logic [15:0] d;
        host_model_inst.send_word({`OP_PLAY, 10'h003});
        wait_start;
        cmd({`OP_PAUSE, 10'h000});
        check(paused, 1);
        d = dacCurrentOutput;
        repeat (4) begin
            wait_clk(1);
            check({pwmSpeakerOutA, pwmSpeakerOutB}, 0);
        end
        cmd({`OP_RESUME, 10'h000});
        check(paused, 0);
        check(dacCurrentOutput, d);
        done_pulse;
    endtask
    task automatic t_volume;
        word_t      vc [7];
        logic [3:0] ve [7];
        vc = '{{`OP_VOL_SET, 10'h005}, {`OP_VOL_UP, 10'h0}, {`OP_VOL_DOWN, 10'h0},
               {`OP_VOL_SET, 10'h0}, {`OP_VOL_UP, 10'h0}, {`OP_VOL_SET, 10'h00f},
               {`OP_VOL_DOWN, 10'h0}};
        ve = '{4'h5, 4'h4, 4'h5, 4'h0, 4'h0, 4'hf, 4'hf};
        for (int i = 0; i < 7; i++) begin
            cmd(vc[i]);
            check(volumeLevel, ve[i]);
        end
    endtask
    task automatic t_invalid;
        cmd(16'h0000);
        rd;
        check(st[2], 1);
        check(volumeLevel, 4'hf);
        cmd({`OP_VOL_SET, 10'h003});
        rd;
        check(st[2], 0);
        check(volumeLevel, 4'h3);
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        nrst = 1'b0;
        voiceDone = 1'b0;
        pwmSourceA = 1'b0;
        pwmSourceB = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        nrst = 1'b1;
        wait_clk(2);
        host_model_inst.stop_frame;
        t_power;
        t_play;
        t_pause;
        t_volume;
        t_invalid;
        tally_and_finish;
    end
    initial begin
        #3000000;
        errors++;
        tally_and_finish;
    end
endmodule // testbench

bind two_wire_voice_command_port voice_cmd_chk #(.RAMP_CYCLES(RAMP_CYCLES)) voice_cmd_chk_inst (
    .clk, .nrst, .playStart, .playing, .programmableIndicatorOutput, .loadIndication,
    .paused, .pwmSpeakerOutA, .pwmSpeakerOutB, .pwmSourceA, .dacCurrentOutput);
